// file: edcu_consts.svh
`ifndef EDCU_CONSTS_SVH
`define EDCU_CONSTS_SVH
// Register byte offsets on the bus, one aligned word each.
`define EDCU_OFF_CSR 8'h00
`define EDCU_OFF_BAR 8'h04
`define EDCU_OFF_DAR 8'h08
`define EDCU_OFF_MPR 8'h0C
`define EDCU_OFF_BAE 8'h10
`define EDCU_OFF_REG5 8'h14
`define EDCU_OFF_REG6 8'h18
`define EDCU_OFF_REG7 8'h1C
`define EDCU_OFF_SPARE 8'h20
`define EDCU_OFF_MAINT 8'h24
`define EDCU_OFF_DSTAT 8'h28
// Field positions.
`define EDCU_CSR_CONTROLLER_ERROR_FLAG 15
`define EDCU_CSR_CONTROLLER_READY_FLAG 7
`define EDCU_CSR_IE 6
`define EDCU_SPARE_SET 15
`define EDCU_SPARE_CLR 14
`define EDCU_DS_ILF 9
`define EDCU_DS_REPL 0
`define EDCU_SW_REV1 8
// Function codes.
`define EDCU_FN_MULTI 3'h0
`define EDCU_FN_WCHECK 3'h1
`define EDCU_FN_WHDR 3'h2
`define EDCU_FN_FORMAT 3'h4
// Values and counts.
`define EDCU_MAINT_KEY 16'hFFFF
`define EDCU_REPL_MARK 16'h2648
`define EDCU_RST_WORD 16'h0000
`define EDCU_SILO_LAST 8'hFE
`define EDCU_HDR_LAST 9'h002
`define EDCU_DATA_LAST 9'h0FF
`define EDCU_REV_SHORT 3'h1
`define EDCU_REV_LONG 3'h4
`define EDCU_SEEK_SETTLE 9'h004
`define EDCU_FW_NCYL 8'h76
`define EDCU_FW_NTRK 8'h77
`define EDCU_FW_NSEC 8'h78
`define EDCU_ILV 16'h0003
`endif

// file: edcu_pkg.sv
package edcu_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_FILL = 3'b001,
      ST_SEEK = 3'b010,
      ST_HDR = 3'b011,
      ST_DATA = 3'b100,
      ST_DONE = 3'b101
   } edcu_state_t;
   typedef struct packed {
      logic [15:0] cyl;
      logic [7:0] trk;
      logic [7:0] sec;
   } edcu_addr_t;
   typedef struct packed {
      logic valid;
      logic hdr;
      logic [15:0] word;
   } edcu_dword_t;
endpackage : edcu_pkg

// file: edcu_crc.sv
`timescale 1ns/1ps
module edcu_crc (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clr,
   input wire logic upd,
   input wire logic [15:0] din,
   output logic [15:0] crc
);
   logic [15:0] crc_q;

   // One word folded into the running sum, most significant bit first.
   function automatic logic [15:0] edcu_crc_step(input logic [15:0] c, input logic [15:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 15; i >= 0; i--) begin
         r = (r[15] ^ d[i]) ? ((r << 1) ^ 16'h1021) : (r << 1);
      end
      return r;
   endfunction : edcu_crc_step

   // Clear restarts the sum; clear wins because it marks a new header.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         crc_q <= 16'hFFFF;
      end else if (clr) begin
         crc_q <= 16'hFFFF;
      end else if (upd) begin
         crc_q <= edcu_crc_step(crc_q, din);
      end
   end

   assign crc = crc_q;
endmodule : edcu_crc

// file: edcu_silo.sv
`timescale 1ns/1ps
module edcu_silo (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clr,
   input wire logic push,
   input wire logic [15:0] din,
   input wire logic pop,
   output logic [15:0] head,
   output logic empty
);
   logic [15:0] mem_q [0:254];
   logic [7:0] wp_q;
   logic [7:0] rp_q;

   // Storage has no reset; only the pointers need a defined value.
   always_ff @(posedge hclk) begin
      if (push) begin
         mem_q[wp_q] <= din;
      end
   end

   // A push beyond the last slot is dropped; the filler never issues one.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wp_q <= 8'h00;
         rp_q <= 8'h00;
      end else if (clr) begin
         wp_q <= 8'h00;
         rp_q <= 8'h00;
      end else begin
         if (push && wp_q != 8'hFF) begin
            wp_q <= wp_q + 8'h01;
         end
         if (pop && !empty) begin
            rp_q <= rp_q + 8'h01;
         end
      end
   end

   assign empty = (rp_q == wp_q);
   assign head = empty ? 16'h0000 : mem_q[rp_q];
endmodule : edcu_silo

// file: edcu_top.sv
`timescale 1ns/1ps
`include "edcu_consts.svh"
module edcu_top #(
   parameter logic [15:0] NCYL = 16'h0100,
   parameter logic [7:0] NTRK = 8'h02,
   parameter logic [7:0] NSEC = 8'h14
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic subsys_clear,
   input wire logic bus_init,
   input wire logic drv_index,
   input wire logic drv_on_target,
   input wire logic drv_accept,
   input wire logic [1:0] phys_wp,
   output edcu_pkg::edcu_dword_t drv_wr,
   output edcu_pkg::edcu_addr_t drv_target,
   output logic drv_busy,
   output logic [3:0] logical_wp,
   output logic cmd_irq
);
   edcu_pkg::edcu_state_t st_q, st_d;
   edcu_pkg::edcu_addr_t pos_q, pos_d, nxt_q;
   edcu_pkg::edcu_addr_t pos_nx;
   edcu_pkg::edcu_dword_t dw_q, dw_d;
   logic [6:0] s1_q, s2_q;
   logic idx_old_q;
   logic [15:0] csr_q, bar_q, dar_q, mpr_q, bae_q, reg5_q, reg6_q, reg7_q, spare_q, dstat_q;
   logic controller_ready_flag_q, controller_error_flag_q, ena_q, fmt_q, irq_q, repl_d;
   logic [11:0] sw_q;
   logic [3:0] wp_q, lwp_q;
   logic [8:0] cnt_q, cnt_d;
   logic [2:0] rev_q, rev_d;
   logic wr_q;
   logic [7:0] wa_q;
   logic [31:0] hrdata_q;
   logic [15:0] rd_word, fw_word, hdr_w1, hdr_w2, out_word, crc, silo_head;
   logic [7:0] lsec;
   logic silo_empty, abort;

   // Any of the three command codes this unit owns.
   function automatic logic edcu_is_ext(input logic [2:0] fn);
      return fn == `EDCU_FN_MULTI || fn == `EDCU_FN_WHDR || fn == `EDCU_FN_FORMAT;
   endfunction : edcu_is_ext

   // Sector that follows a given one, walking sector, track, then cylinder.
   function automatic edcu_pkg::edcu_addr_t edcu_next(input edcu_pkg::edcu_addr_t a);
      edcu_pkg::edcu_addr_t r;
      r = a;
      if (a.sec != NSEC - 8'h01) begin
         r.sec = a.sec + 8'h01;
      end else begin
         r.sec = 8'h00;
         if (a.trk != NTRK - 8'h01) begin
            r.trk = a.trk + 8'h01;
         end else begin
            r.trk = 8'h00;
            r.cyl = a.cyl + 16'h0001;
         end
      end
      return r;
   endfunction : edcu_next

   // Revolutions allowed for a header search; switch bit 12 or a write-check code picks the short limit.
   function automatic logic [2:0] edcu_rev_limit(input logic sw12, input logic [2:0] fn);
      return (sw12 || fn == `EDCU_FN_WCHECK) ? `EDCU_REV_SHORT : `EDCU_REV_LONG;
   endfunction : edcu_rev_limit

   // Pins from the drive and the bus come from outside; two flops first.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_q <= 7'h00;
         s2_q <= 7'h00;
         idx_old_q <= 1'b0;
      end else begin
         s1_q <= {phys_wp, drv_accept, drv_on_target, drv_index, bus_init, subsys_clear};
         s2_q <= s1_q;
         idx_old_q <= s2_q[2];
      end
   end

   wire clr_s = s2_q[0] | s2_q[1];
   wire idx_pulse = s2_q[2] & ~idx_old_q;
   wire tgt_s = s2_q[3];
   wire acc_s = s2_q[4];
   wire [1:0] pwp_s = s2_q[6:5];

   // Bus decode: a zero-wait slave, writes land at the end of the data phase.
   wire ap = hsel & hready & htrans[1];
   wire [7:0] ra = haddr[7:0];
   wire busy = ~controller_ready_flag_q;
   wire [15:0] wd = hwdata[15:0];
   wire wok = wr_q & ~busy;
   wire w_csr = wok && wa_q == `EDCU_OFF_CSR;
   wire start = w_csr & ~wd[`EDCU_CSR_CONTROLLER_READY_FLAG];
   wire [2:0] fn = wd[3:1];
   wire ext_ok = start & edcu_is_ext(fn) & ena_q;
   wire illegal = start & edcu_is_ext(fn) & ~ena_q;
   wire quick = start & ~ext_ok;
   wire pop = ap & ~hwrite & (ra == `EDCU_OFF_MPR) & ~silo_empty;
   wire trig = wok && wa_q == `EDCU_OFF_MAINT && wd == `EDCU_MAINT_KEY
      && spare_q[`EDCU_SPARE_SET] && !spare_q[`EDCU_SPARE_CLR];

   // Read selection; the maintenance register reads back as zero.
   always_comb begin
      case (ra)
         `EDCU_OFF_CSR: rd_word = {controller_error_flag_q, csr_q[14:8], controller_ready_flag_q, csr_q[6:0]};
         `EDCU_OFF_BAR: rd_word = bar_q;
         `EDCU_OFF_DAR: rd_word = dar_q;
         `EDCU_OFF_MPR: rd_word = silo_empty ? mpr_q : silo_head;
         `EDCU_OFF_BAE: rd_word = bae_q;
         `EDCU_OFF_REG5: rd_word = reg5_q;
         `EDCU_OFF_REG6: rd_word = reg6_q;
         `EDCU_OFF_REG7: rd_word = reg7_q;
         `EDCU_OFF_SPARE: rd_word = spare_q;
         `EDCU_OFF_DSTAT: rd_word = dstat_q;
         default: rd_word = 16'h0000;
      endcase
   end

   // Firmware block image: registers first, next-sector address at 118-120.
   always_comb begin
      case (cnt_q[7:0])
         8'h00: fw_word = {controller_error_flag_q, csr_q[14:8], controller_ready_flag_q, csr_q[6:0]};
         8'h01: fw_word = bar_q;
         8'h02: fw_word = dar_q;
         8'h03: fw_word = mpr_q;
         8'h04: fw_word = bae_q;
         8'h05: fw_word = reg5_q;
         8'h06: fw_word = reg6_q;
         8'h07: fw_word = dstat_q;
         8'h08: fw_word = NCYL;
         8'h09: fw_word = {8'h00, NTRK};
         8'h0A: fw_word = {8'h00, NSEC};
         8'h0B: fw_word = {4'h0, sw_q};
         `EDCU_FW_NCYL: fw_word = nxt_q.cyl;
         `EDCU_FW_NTRK: fw_word = {8'h00, nxt_q.trk};
         `EDCU_FW_NSEC: fw_word = {8'h00, nxt_q.sec};
         default: fw_word = 16'h0000;
      endcase
   end

   // Physical slot p carries logical pair 2*(p*3 mod n); hosts never see it.
   wire [15:0] ilv_full = (16'(pos_q.sec) * `EDCU_ILV) % 16'(NSEC);
   assign lsec = {ilv_full[6:0], 1'b0};

   // Format builds standard headers; header write uses what software loaded.
   assign hdr_w1 = fmt_q ? {pos_q.cyl[8:0], pos_q.trk[0], lsec[5:0]} : dar_q;
   assign hdr_w2 = fmt_q ? {pos_q.cyl[7:0], pos_q.trk} : bae_q;

   // Bad sector file image: pack id twice, then zeros, then ones.
   always_comb begin
      if (st_q == edcu_pkg::ST_HDR) begin
         case (cnt_q[1:0])
            2'h0: out_word = hdr_w1;
            2'h1: out_word = hdr_w2;
            default: out_word = crc;
         endcase
      end else if (cnt_q < 9'h002) begin
         out_word = mpr_q;
      end else if (cnt_q < 9'h004) begin
         out_word = 16'h0000;
      end else begin
         out_word = 16'hFFFF;
      end
   end

   // Command sequencer.
   always_comb begin
      st_d = st_q;
      pos_d = pos_q;
      cnt_d = cnt_q;
      rev_d = rev_q;
      dw_d = '0;
      abort = 1'b0;
      case (st_q)
         edcu_pkg::ST_IDLE: begin
            cnt_d = 9'h000;
            rev_d = 3'h0;
            if (ext_ok && fn == `EDCU_FN_MULTI) begin
               st_d = edcu_pkg::ST_FILL;
            end else if (ext_ok && fn == `EDCU_FN_WHDR) begin
               pos_d = {reg5_q, reg6_q[15:8], reg6_q[7:0]};
               st_d = edcu_pkg::ST_SEEK;
            end else if (ext_ok) begin
               pos_d = '0;
               st_d = edcu_pkg::ST_SEEK;
            end
         end
         edcu_pkg::ST_FILL: begin
            cnt_d = cnt_q + 9'h001;
            if (cnt_q[7:0] == `EDCU_SILO_LAST) begin
               st_d = edcu_pkg::ST_DONE;
            end
         end
         edcu_pkg::ST_SEEK: begin
            // The synchronised on-target level still shows the old slot for a few cycles.
            if (cnt_q != `EDCU_SEEK_SETTLE) begin
               cnt_d = cnt_q + 9'h001;
            end
            if (tgt_s && cnt_q == `EDCU_SEEK_SETTLE) begin
               cnt_d = 9'h000;
               st_d = edcu_pkg::ST_HDR;
            end else if (idx_pulse) begin
               rev_d = rev_q + 3'h1;
               if (rev_q + 3'h1 == edcu_rev_limit(sw_q[`EDCU_SW_REV1], csr_q[3:1])) begin
                  abort = 1'b1;
                  st_d = edcu_pkg::ST_DONE;
               end
            end
         end
         edcu_pkg::ST_HDR: begin
            if (acc_s) begin
               dw_d = {1'b1, 1'b1, out_word};
               cnt_d = cnt_q + 9'h001;
               if (cnt_q == `EDCU_HDR_LAST) begin
                  cnt_d = 9'h000;
                  st_d = edcu_pkg::ST_DATA;
               end
            end
         end
         edcu_pkg::ST_DATA: begin
            if (acc_s) begin
               dw_d = {1'b1, 1'b0, out_word};
               cnt_d = cnt_q + 9'h001;
               if (cnt_q == `EDCU_DATA_LAST) begin
                  st_d = edcu_pkg::ST_DONE;
                  if (fmt_q && pos_nx.cyl != NCYL) begin
                     pos_d = pos_nx;
                     rev_d = 3'h0;
                     cnt_d = 9'h000;
                     st_d = edcu_pkg::ST_SEEK;
                  end
               end
            end
         end
         edcu_pkg::ST_DONE: st_d = edcu_pkg::ST_IDLE;
         default: st_d = edcu_pkg::ST_IDLE;
      endcase
   end

   // Sector after the current one, for the format walk and the dump.
   assign pos_nx = edcu_next(pos_q);

   assign repl_d = (st_q == edcu_pkg::ST_DONE) && !fmt_q && csr_q[3:1] == `EDCU_FN_WHDR
      && bae_q[7:0] == 8'(`EDCU_REPL_MARK);

   // Sequencer state and drive-side outputs.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= edcu_pkg::ST_IDLE;
         pos_q <= '0;
         cnt_q <= 9'h000;
         rev_q <= 3'h0;
         dw_q <= '0;
      end else begin
         st_q <= st_d;
         pos_q <= pos_d;
         cnt_q <= cnt_d;
         rev_q <= rev_d;
         dw_q <= dw_d;
      end
   end

   // Format flag and the next-sector address kept for the diagnostic dump.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fmt_q <= 1'b0;
         nxt_q <= '0;
      end else begin
         if (ext_ok) begin
            fmt_q <= (fn == `EDCU_FN_FORMAT);
         end
         if (st_q == edcu_pkg::ST_DATA && acc_s && cnt_q == `EDCU_DATA_LAST) begin
            nxt_q <= pos_nx;
         end
      end
   end

   // Enable: a bus or subsystem clear outranks a trigger in the same cycle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ena_q <= 1'b0;
      end else if (clr_s || start) begin
         ena_q <= 1'b0;
      end else if (trig) begin
         ena_q <= 1'b1;
      end
   end

   // Ready, error and interrupt; a clear only comes with a new start.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         controller_ready_flag_q <= 1'b1;
         controller_error_flag_q <= 1'b0;
         irq_q <= 1'b0;
         dstat_q <= `EDCU_RST_WORD;
      end else begin
         if (ext_ok) begin
            controller_ready_flag_q <= 1'b0;
         end else if (st_q == edcu_pkg::ST_DONE) begin
            controller_ready_flag_q <= 1'b1;
         end
         if (start) begin
            controller_error_flag_q <= illegal;
            dstat_q[`EDCU_DS_ILF] <= illegal;
            dstat_q[`EDCU_DS_REPL] <= 1'b0;
         end else begin
            if (abort) begin
               controller_error_flag_q <= 1'b1;
            end
            if (repl_d) begin
               dstat_q[`EDCU_DS_REPL] <= 1'b1;
            end
         end
         // A command that ends at once takes its enable from the word being written.
         irq_q <= (quick & wd[`EDCU_CSR_IE]) | ((st_q == edcu_pkg::ST_DONE) & csr_q[`EDCU_CSR_IE]);
      end
   end

   // Protection and switches; only power-up reset clears the switches.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wp_q <= 4'h0;
         sw_q <= 12'h000;
         lwp_q <= 4'h0;
      end else begin
         if (ext_ok && fn == `EDCU_FN_MULTI) begin
            wp_q <= mpr_q[3:0];
            sw_q <= mpr_q[15:4];
         end
         lwp_q <= wp_q | {pwp_s[1], pwp_s[1], pwp_s[0], pwp_s[0]};
      end
   end

   // Register writes; all are refused while a command runs.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         csr_q <= `EDCU_RST_WORD;
         {bar_q, dar_q, mpr_q, bae_q} <= {4{`EDCU_RST_WORD}};
         {reg5_q, reg6_q, reg7_q, spare_q} <= {4{`EDCU_RST_WORD}};
      end else if (wok) begin
         case (wa_q)
            `EDCU_OFF_CSR: csr_q <= wd;
            `EDCU_OFF_BAR: bar_q <= wd;
            `EDCU_OFF_DAR: dar_q <= wd;
            `EDCU_OFF_MPR: mpr_q <= wd;
            `EDCU_OFF_BAE: bae_q <= wd;
            `EDCU_OFF_REG5: reg5_q <= wd;
            `EDCU_OFF_REG6: reg6_q <= wd;
            `EDCU_OFF_REG7: reg7_q <= wd;
            `EDCU_OFF_SPARE: spare_q <= wd;
            default: csr_q <= csr_q;
         endcase
      end
   end

   // Bus phase tracking; read data is captured at the address phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         wa_q <= 8'h00;
         hrdata_q <= 32'h0000_0000;
      end else begin
         wr_q <= ap & hwrite;
         wa_q <= ra;
         if (ap && !hwrite) begin
            hrdata_q <= {16'h0000, rd_word};
         end
      end
   end

   // Silo holds the dump; it is emptied when a new dump starts.
   edcu_silo edcu_silo_inst (
      .hclk(hclk),
      .hresetn(hresetn),
      .clr(ext_ok && fn == `EDCU_FN_MULTI),
      .push(st_q == edcu_pkg::ST_FILL),
      .din(fw_word),
      .pop(pop),
      .head(silo_head),
      .empty(silo_empty)
   );

   // Header sum restarts on every search and folds the two header words.
   edcu_crc edcu_crc_inst (
      .hclk(hclk),
      .hresetn(hresetn),
      .clr(st_q == edcu_pkg::ST_SEEK),
      .upd(st_q == edcu_pkg::ST_HDR && acc_s && cnt_q != `EDCU_HDR_LAST),
      .din(out_word),
      .crc(crc)
   );

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;
   assign drv_wr = dw_q;
   assign drv_target = pos_q;
   assign drv_busy = ~controller_ready_flag_q;
   assign logical_wp = lwp_q;
   assign cmd_irq = irq_q;
endmodule : edcu_top

// file: edcu_monitor.sv
`timescale 1ns/1ps
module edcu_monitor (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic drv_accept,
   input wire logic [1:0] phys_wp,
   input wire edcu_pkg::edcu_dword_t drv_wr,
   input wire logic drv_busy,
   input wire logic [3:0] logical_wp,
   input wire logic cmd_irq
);
   // Header and data words as the drive sees them.
   wire hw = drv_wr.valid & drv_wr.hdr;
   wire dw = drv_wr.valid & ~drv_wr.hdr;
   logic [8:0] dcnt_q;
   logic [8:0] dcnt_d;
   // Data words since the last header, so an overlong sector is caught.
   assign dcnt_d = hw ? 9'h000 : dcnt_q + {8'h00, dw};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dcnt_q <= 9'h000;
      end else begin
         dcnt_q <= dcnt_d;
      end
   end
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence s_hdr_run;
      hw [*3] ##1 !hw;
   endsequence
   sequence s_irq_once;
      cmd_irq ##1 !cmd_irq;
   endsequence
   a_irq_one_pulse: assert property ($rose(cmd_irq) |-> s_irq_once) else $error("irq not one cycle");
   a_irq_when_ready: assert property (cmd_irq |-> !drv_busy) else $error("irq while busy");
   a_word_while_busy: assert property (drv_wr.valid |-> drv_busy) else $error("word while idle");
   a_word_on_accept: assert property (drv_wr.valid |-> $past(drv_accept, 2) || $past(drv_accept, 3)
      || $past(drv_accept, 4)) else $error("word without accept");
   a_hdr_three_words: assert property ($rose(hw) |-> s_hdr_run) else $error("header not three words");
   a_hdr_even_sector: assert property ($rose(hw) |-> !drv_wr.word[0]) else $error("odd header");
   a_data_bound: assert property (dw |-> dcnt_q < 9'h100) else $error("sector overlong");
   a_wp_unit_one: assert property (phys_wp[1] [*5] |=> logical_wp[3:2] == 2'b11) else $error("wp lost");
endmodule : edcu_monitor

// file: edcu_drive_model.sv
`timescale 1ns/1ps
module edcu_drive_model #(
   parameter int REV = 200,
   parameter int LAT = 12
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic drv_busy,
   input wire edcu_pkg::edcu_addr_t drv_target,
   input wire logic stall,
   output logic drv_index,
   output logic drv_on_target,
   output logic drv_accept
);
   int rev_q;
   int wait_q;
   edcu_pkg::edcu_addr_t last_q;
   // The disk turns always; the slot is found LAT cycles after the target settles.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rev_q <= 0;
         wait_q <= 0;
         last_q <= '0;
      end else begin
         rev_q <= (rev_q == REV - 1) ? 0 : rev_q + 1;
         wait_q <= (!drv_busy || drv_target !== last_q) ? 0 : wait_q + int'(wait_q < LAT);
         last_q <= drv_target;
      end
   end
   // A stalled drive never finds its slot, which forces the search limit.
   assign drv_index = rev_q < 4;
   assign drv_on_target = drv_busy && !stall && wait_q == LAT;
   assign drv_accept = drv_busy && !stall;
endmodule : edcu_drive_model

// file: edcu_bench.sv
`timescale 1ns/1ps
`include "edcu_consts.svh"
module edcu_bench;
   logic hclk, hresetn, hsel, hwrite, subsys_clear, bus_init, stall;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans, phys_wp;
   logic [2:0] hsize;
   wire hready, hresp, drv_index, drv_on_target, drv_accept, drv_busy, cmd_irq;
   wire [3:0] logical_wp;
   edcu_pkg::edcu_dword_t drv_wr;
   edcu_pkg::edcu_addr_t drv_target;
   logic [15:0] hq[$], dq[$], w[256];
   int num_errors = 0, total_checks = 0, n;
   edcu_top #(.NCYL(16'h0002), .NTRK(8'h02), .NSEC(8'h04)) edcu_top_inst (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .subsys_clear(subsys_clear),
      .bus_init(bus_init), .drv_index(drv_index), .drv_on_target(drv_on_target), .drv_accept(drv_accept),
      .phys_wp(phys_wp), .drv_wr(drv_wr), .drv_target(drv_target), .drv_busy(drv_busy),
      .logical_wp(logical_wp), .cmd_irq(cmd_irq));
   edcu_drive_model edcu_drive_model_inst (.hclk(hclk), .hresetn(hresetn), .drv_busy(drv_busy),
      .drv_target(drv_target), .stall(stall), .drv_index(drv_index), .drv_on_target(drv_on_target),
      .drv_accept(drv_accept));
   // The clock toggles every half period of 25 ns.
   always #25 hclk = ~hclk;
   // Words handed to the drive are kept for the command that started them.
   always @(posedge hclk) begin
      if (drv_wr.valid === 1'b1) begin
         if (drv_wr.hdr) hq.push_back(drv_wr.word);
         else dq.push_back(drv_wr.word);
      end
   end
   task test_done;
      if (num_errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : test_done
   task lost;
      num_errors++;
      test_done();
   endtask : lost
   task chk(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Header check word, seeded with all ones, most significant bit first.
   function automatic logic [15:0] crc16(input logic [31:0] m);
      logic [15:0] c;
      c = 16'hFFFF;
      for (int i = 31; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ m[i]) ? 16'h1021 : 16'h0000);
      return c;
   endfunction : crc16
   task edge_rdy;
      int i;
      for (i = 0; i < 20; i++) begin
         @(posedge hclk);
         if (hready === 1'b1) break;
      end
      if (i == 20) lost();
   endtask : edge_rdy
   // One single word transfer; read data is taken at the end of the data phase.
   task ahb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= wr_en;
      edge_rdy();
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      edge_rdy();
      q = hrdata;
   endtask : ahb
   task wr(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, a, d);
   endtask : wr
   task rd(input logic [7:0] a);
      ahb(1'b0, a, 32'h0);
   endtask : rd
   task enable;
      wr(`EDCU_OFF_SPARE, 32'h0000_8000);
      wr(`EDCU_OFF_MAINT, 32'h0000_FFFF);
   endtask : enable
   // Start a command with interrupts on and wait for its completion pulse.
   task run(input logic [2:0] fn);
      hq.delete();
      dq.delete();
      wr(`EDCU_OFF_CSR, {25'h0, 1'b1, 2'h0, fn, 1'b0});
      for (n = 0; n < 20000; n++) begin
         @(posedge hclk);
         if (cmd_irq === 1'b1) break;
      end
      if (n == 20000) lost();
   endtask : run
   task s_reset;
      rd(`EDCU_OFF_CSR);
      chk(q, 32'h0000_0080);
      chk({hresp, hready}, 2'b01);
      rd(`EDCU_OFF_DSTAT);
      chk(q, 32'h0);
      wr(`EDCU_OFF_REG5, 32'h0000_1234);
      rd(`EDCU_OFF_REG5);
      chk(q, 32'h0000_1234);
      rd(8'h3C);
      chk(q, 32'h0);
   endtask : s_reset
   // Extended codes refused when never enabled, or after each way of losing it.
   task s_refused;
      for (int k = 0; k < 6; k++) begin
         if (k > 2) begin
            enable();
            if (k == 5) run(3'h3);
            else begin
               if (k == 3) subsys_clear <= 1'b1;
               else bus_init <= 1'b1;
               repeat (4) @(posedge hclk);
               subsys_clear <= 1'b0;
               bus_init <= 1'b0;
               repeat (4) @(posedge hclk);
            end
         end
         run(k < 3 ? 3'(2 * k) : `EDCU_FN_FORMAT);
         rd(`EDCU_OFF_CSR);
         chk({q[15], q[7]}, 2'b11);
         rd(`EDCU_OFF_DSTAT);
         chk(q[9], 1'b1);
      end
   endtask : s_refused
   // A plain header and then a replaced-track header at the same slot.
   task s_hdr;
      logic [15:0] e;
      for (int k = 0; k < 2; k++) begin
         e = k ? 16'h0148 : 16'h0112;
         enable();
         wr(`EDCU_OFF_REG5, 32'h0000_0001);
         wr(`EDCU_OFF_REG6, 32'h0000_0102);
         wr(`EDCU_OFF_DAR, 32'h0000_0104);
         wr(`EDCU_OFF_BAE, {16'h0, e});
         run(`EDCU_FN_WHDR);
         chk(drv_target, 32'h0001_0102);
         chk({hq.size(), hq[0], hq[1]}, {32'h3, 16'h0104, e});
         chk(hq[2], crc16({16'h0104, e}));
         rd(`EDCU_OFF_DSTAT);
         chk(q[0], k[0]);
         rd(`EDCU_OFF_CSR);
         chk(q[15], 1'b0);
      end
   endtask : s_hdr
   task s_multi;
      enable();
      wr(`EDCU_OFF_MPR, 32'h0000_1005);
      run(`EDCU_FN_MULTI);
      chk(logical_wp, 4'h5);
      phys_wp <= 2'b10;
      repeat (6) @(posedge hclk);
      chk(logical_wp, 4'hD);
      phys_wp <= 2'b00;
      repeat (6) @(posedge hclk);
      chk(logical_wp, 4'h5);
      for (int k = 0; k < 256; k++) begin
         rd(`EDCU_OFF_MPR);
         w[k] = q[15:0];
      end
      chk({w[3], w[8], w[9], w[10]}, 64'h1005_0002_0002_0004);
      chk({w[118], w[119], w[120]}, 48'h0001_0001_0003);
      chk({w[11], w[254], w[255]}, 48'h0100_0000_1005);
   endtask : s_multi
   // A drive that never finds the slot; the switch sets how long the search lasts.
   task s_search;
      stall <= 1'b1;
      enable();
      run(`EDCU_FN_WHDR);
      chk(n <= 450, 1'b1);
      rd(`EDCU_OFF_CSR);
      chk(q[15], 1'b1);
      enable();
      wr(`EDCU_OFF_MPR, 32'h0000_EFF5);
      run(`EDCU_FN_MULTI);
      enable();
      run(`EDCU_FN_WHDR);
      chk(n >= 550 && n <= 1100, 1'b1);
      stall <= 1'b0;
   endtask : s_search
   task s_format;
      enable();
      wr(`EDCU_OFF_MPR, 32'h0000_00AB);
      wr(`EDCU_OFF_DAR, 32'h0000_1234);
      wr(`EDCU_OFF_BAR, 32'h0000_5678);
      run(`EDCU_FN_FORMAT);
      chk({hq.size(), dq.size()}, {32'h30, 32'h1000});
      chk({dq[0], dq[1], dq[2], dq[255]}, 64'h00AB_00AB_0000_FFFF);
      chk({hq[0], hq[1], hq[2]}, {32'h0, crc16(32'h0)});
      chk(hq[3], 16'h0006);
      chk({hq[12], hq[13]}, 32'h0040_0001);
   endtask : s_format
   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      {hsel, hwrite, subsys_clear, bus_init, stall} = 5'h0;
      {haddr, hwdata} = 64'h0;
      htrans = 2'h0;
      phys_wp = 2'h0;
      hsize = 3'h2;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      s_reset();
      s_refused();
      s_hdr();
      s_multi();
      s_search();
      s_format();
      test_done();
   end
endmodule : edcu_bench
bind edcu_top edcu_monitor edcu_monitor_inst (.hclk(hclk), .hresetn(hresetn), .drv_accept(drv_accept),
   .phys_wp(phys_wp), .drv_wr(drv_wr), .drv_busy(drv_busy), .logical_wp(logical_wp), .cmd_irq(cmd_irq));
